/* hdl/iafu_pkg.sv */
/*
  Constants for the integer arithmetic and flag unit: register map, control
  fields, flag bit positions, reset values and the operation codes.
  Assumes a 32-bit Avalon-MM slave port with byte addresses.
*/
`default_nettype none

package iafu_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [4:0] IAFU_OFS_CTRL  = 5'h00;
  localparam logic [4:0] IAFU_OFS_DEST  = 5'h04;
  localparam logic [4:0] IAFU_OFS_SRC   = 5'h08;
  localparam logic [4:0] IAFU_OFS_EXT   = 5'h0C;
  localparam logic [4:0] IAFU_OFS_FLAGS = 5'h10;

  // ==========================================================================
  // Control word fields
  localparam int IAFU_CTRL_OP_LSB = 0;
  localparam int IAFU_CTRL_OP_W   = 4;
  localparam int IAFU_CTRL_WORD   = 4;

  // ==========================================================================
  // Flag bit positions within the flags register
  localparam int IAFU_FLG_CARRY  = 0;
  localparam int IAFU_FLG_PARITY = 1;
  localparam int IAFU_FLG_HALF   = 2;
  localparam int IAFU_FLG_ZERO   = 3;
  localparam int IAFU_FLG_SIGN   = 4;
  localparam int IAFU_FLG_OVER   = 5;
  localparam int IAFU_FLG_W      = 6;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] IAFU_RST_DATA  = 16'h0000;
  localparam logic [5:0]  IAFU_RST_FLAGS = 6'h00;
  localparam logic [3:0]  IAFU_RST_OP    = 4'h0;

  // ==========================================================================
  // Decimal correction constants
  localparam logic [7:0] IAFU_NIB_FIX  = 8'h06;
  localparam logic [7:0] IAFU_HI_FIX   = 8'h60;
  localparam logic [3:0] IAFU_DIG_MAX  = 4'h9;
  localparam logic [7:0] IAFU_PACK_MAX = 8'h99;
  localparam logic [7:0] IAFU_TEN      = 8'h0A;
  localparam logic [7:0] IAFU_LO_NIB   = 8'h0F;

  // ==========================================================================
  // Operation codes
  typedef enum logic [3:0] {
    IAFU_OP_SUM          = 4'h0,
    IAFU_OP_SUM_C        = 4'h1,
    IAFU_OP_PLUS1        = 4'h2,
    IAFU_OP_USUM_FIX     = 4'h3,
    IAFU_OP_PSUM_FIX     = 4'h4,
    IAFU_OP_DIFF         = 4'h5,
    IAFU_OP_DIFF_B       = 4'h6,
    IAFU_OP_MINUS1       = 4'h7,
    IAFU_OP_TWOS         = 4'h8,
    IAFU_OP_COMPARE      = 4'h9,
    IAFU_OP_UDIFF_FIX    = 4'hA,
    IAFU_OP_PDIFF_FIX    = 4'hB,
    IAFU_OP_UPROD        = 4'hC,
    IAFU_OP_SPROD        = 4'hD,
    IAFU_OP_UPROD_FIX    = 4'hE,
    IAFU_OP_NOP          = 4'hF
  } iafu_op_t;

endpackage : iafu_pkg

`default_nettype wire

/* hdl/iafu_core.sv */
/*
  Integer arithmetic and flag unit: add, subtract, increment, decrement,
  negate, compare, multiply and the decimal adjust steps, with six flags.
  Assumes an Avalon-MM master on the same clock; one access at a time.
*/
`default_nettype none

// Functional notes
// - Add writes sum of byte or word operands, updates all six flags
// - Add with carry adds one more when carry set, updates six flags
// - Increment adds one, updates five flags, carry unchanged
// - Unpacked add fix makes low byte one digit, updates half-carry, carry
// - Packed add fix makes two packed digits, updates five flags
// - Subtract writes destination minus source, updates all six flags
// - Subtract with borrow also removes one when carry set, six flags
// - Decrement subtracts one, updates five flags, carry unchanged
// - Negate replaces operand by zero minus it, updates six flags
// - Negating most negative value keeps it and sets overflow
// - Negate sets carry for nonzero operand, clears it for zero
// - Compare subtracts only for flags, operands unchanged
// - Unpacked subtract fix makes one digit, updates half-carry, carry
// - Packed subtract fix makes two packed digits, updates five flags
// - Unsigned multiply into high:low byte or extension:accumulator word
// - Unsigned multiply sets carry and overflow when upper half nonzero
// - Signed multiply into the same register pairs
// - Signed multiply flags set when upper half is not sign extension
// - Unpacked multiply fix gives two digits, updates parity, sign, zero
// - Parity set when low eight result bits hold even ones
// - Half-carry set on carry out of or borrow into low nibble
// - Carry set on carry out of or borrow into top bit
// - Sign equals top result bit, bit 7 or bit 15
module iafu_core
  import iafu_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        ce,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Datapath state toward the register file
  output logic      [15:0] acc_word,
  output logic      [15:0] ext_word,
  output logic      [5:0]  flags
);

  // ==========================================================================
  // Helpers
  function automatic logic even_ones(input logic [7:0] v);
    even_ones = ~^v;
  endfunction : even_ones

  function automatic logic [15:0] merge_be(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    merge_be = old;
    if (be[0]) begin
      merge_be[7:0] = wd[7:0];
    end
    if (be[1]) begin
      merge_be[15:8] = wd[15:8];
    end
  endfunction : merge_be

  // ==========================================================================
  // Bus handshake
  logic        wait_q;
  logic [31:0] rdata_q;
  logic [15:0] dest_q;
  logic [15:0] src_q;
  logic [15:0] ext_q;
  logic [5:0]  flags_q;
  logic [3:0]  last_op_q;
  logic        last_word_q;
  logic        req;
  logic        wr_ack;
  logic        exec;

  assign req    = avs_read | avs_write;
  assign wr_ack = avs_write & ~wait_q;
  // Operation runs on the edge that completes the control write
  assign exec   = wr_ack && (avs_address == IAFU_OFS_CTRL) && avs_byteenable[0];

  // One wait cycle per access keeps readdata registered
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wait_q <= 1'b1;
    end else if (ce) begin
      wait_q <= ~(req & wait_q);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (ce && avs_read && wait_q) begin
      case (avs_address)
        IAFU_OFS_CTRL:  rdata_q <= {27'h000_0000, last_word_q, last_op_q};
        IAFU_OFS_DEST:  rdata_q <= {16'h0000, dest_q};
        IAFU_OFS_SRC:   rdata_q <= {16'h0000, src_q};
        IAFU_OFS_EXT:   rdata_q <= {16'h0000, ext_q};
        IAFU_OFS_FLAGS: rdata_q <= {26'h000_0000, flags_q};
        default:        rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Arithmetic core
  iafu_op_t    op;
  logic        wsel;
  logic [15:0] dest_n;
  logic [15:0] ext_n;
  logic [5:0]  flags_n;

  assign op   = iafu_op_t'(avs_writedata[IAFU_CTRL_OP_LSB +: IAFU_CTRL_OP_W]);
  assign wsel = avs_writedata[IAFU_CTRL_WORD];

  always_comb begin
    logic        is_sub;
    logic        cin;
    logic        arith;
    logic        keep_carry;
    logic        no_store;
    logic [15:0] a;
    logic [15:0] b;
    logic [16:0] r;
    logic        sa;
    logic        sb;
    logic        sr;
    logic        cout;
    logic [7:0]  acc_lo;
    logic [7:0]  acc_hi;
    logic [7:0]  t;
    logic        lofix;
    logic        hifix;
    logic [15:0] pu8;
    logic [31:0] pu16;
    logic [15:0] ps8;
    logic [31:0] ps16;
    is_sub   = 1'b0;
    cin      = 1'b0;
    arith    = 1'b1;
    keep_carry = 1'b0;
    no_store = 1'b0;
    a        = dest_q;
    b        = src_q;
    r        = 17'h0_0000;
    sa       = 1'b0;
    sb       = 1'b0;
    sr       = 1'b0;
    cout     = 1'b0;
    acc_lo   = dest_q[7:0];
    acc_hi   = dest_q[15:8];
    t        = 8'h00;
    lofix    = (acc_lo[3:0] > IAFU_DIG_MAX) || flags_q[IAFU_FLG_HALF];
    hifix    = 1'b0;
    pu8      = acc_lo * src_q[7:0];
    pu16     = dest_q * src_q;
    ps8      = 16'($signed(acc_lo) * $signed(src_q[7:0]));
    ps16     = 32'($signed(dest_q) * $signed(src_q));
    dest_n   = dest_q;
    ext_n    = ext_q;
    flags_n  = flags_q;
    case (op)
      IAFU_OP_SUM:       ;
      IAFU_OP_SUM_C:     cin = flags_q[IAFU_FLG_CARRY];
      IAFU_OP_PLUS1: begin
        b          = 16'h0001;
        keep_carry = 1'b1;
      end
      IAFU_OP_DIFF:      is_sub = 1'b1;
      IAFU_OP_DIFF_B: begin
        is_sub = 1'b1;
        cin    = flags_q[IAFU_FLG_CARRY];
      end
      IAFU_OP_MINUS1: begin
        is_sub  = 1'b1;
        b          = 16'h0001;
        keep_carry = 1'b1;
      end
      IAFU_OP_TWOS: begin
        is_sub = 1'b1;
        a      = 16'h0000;
        b      = dest_q;
      end
      IAFU_OP_COMPARE: begin
        is_sub   = 1'b1;
        no_store = 1'b1;
      end
      default:           arith = 1'b0;
    endcase

    // Shared adder; byte mode works on zero-extended low bytes
    if (!wsel) begin
      a = {8'h00, a[7:0]};
      b = {8'h00, b[7:0]};
    end
    if (is_sub) begin
      r = {1'b0, a} - {1'b0, b} - {16'h0000, cin};
    end else begin
      r = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
    end
    sa   = wsel ? a[15] : a[7];
    sb   = wsel ? b[15] : b[7];
    sr   = wsel ? r[15] : r[7];
    cout = wsel ? r[16] : r[8];

    if (arith) begin
      if (!keep_carry) begin
        flags_n[IAFU_FLG_CARRY] = cout;
      end
      flags_n[IAFU_FLG_HALF]   = a[4] ^ b[4] ^ r[4];
      // Negating the most negative value wraps to itself and flags overflow
      flags_n[IAFU_FLG_OVER]   = is_sub ? (sa != sb) && (sr != sa)
                                        : (sa == sb) && (sr != sa);
      flags_n[IAFU_FLG_PARITY] = even_ones(r[7:0]);
      flags_n[IAFU_FLG_SIGN]   = sr;
      flags_n[IAFU_FLG_ZERO]   = wsel ? (r[15:0] == 16'h0000) : (r[7:0] == 8'h00);
      if (!no_store) begin
        dest_n = wsel ? r[15:0] : {dest_q[15:8], r[7:0]};
      end
    end

    case (op)
      IAFU_OP_USUM_FIX: begin
        // Undefined flags are left as they were
        t = acc_lo;
        if (lofix) begin
          t      = acc_lo + IAFU_NIB_FIX;
          acc_hi = acc_hi + 8'h01;
        end
        dest_n                  = {acc_hi, t & IAFU_LO_NIB};
        flags_n[IAFU_FLG_HALF]  = lofix;
        flags_n[IAFU_FLG_CARRY] = lofix;
      end
      IAFU_OP_UDIFF_FIX: begin
        t = acc_lo;
        if (lofix) begin
          t      = acc_lo - IAFU_NIB_FIX;
          acc_hi = acc_hi - 8'h01;
        end
        dest_n                  = {acc_hi, t & IAFU_LO_NIB};
        flags_n[IAFU_FLG_HALF]  = lofix;
        flags_n[IAFU_FLG_CARRY] = lofix;
      end
      IAFU_OP_PSUM_FIX, IAFU_OP_PDIFF_FIX: begin
        hifix = (acc_lo > IAFU_PACK_MAX) || flags_q[IAFU_FLG_CARRY];
        t     = acc_lo;
        if (op == IAFU_OP_PSUM_FIX) begin
          t = lofix ? t + IAFU_NIB_FIX : t;
          t = hifix ? t + IAFU_HI_FIX : t;
        end else begin
          t = lofix ? t - IAFU_NIB_FIX : t;
          t = hifix ? t - IAFU_HI_FIX : t;
        end
        dest_n                   = {acc_hi, t};
        flags_n[IAFU_FLG_HALF]   = lofix;
        flags_n[IAFU_FLG_CARRY]  = hifix;
        flags_n[IAFU_FLG_PARITY] = even_ones(t);
        flags_n[IAFU_FLG_SIGN]   = t[7];
        flags_n[IAFU_FLG_ZERO]   = (t == 8'h00);
      end
      IAFU_OP_UPROD: begin
        if (wsel) begin
          dest_n                  = pu16[15:0];
          ext_n                   = pu16[31:16];
          flags_n[IAFU_FLG_CARRY] = (pu16[31:16] != 16'h0000);
        end else begin
          dest_n                  = pu8;
          flags_n[IAFU_FLG_CARRY] = (pu8[15:8] != 8'h00);
        end
        flags_n[IAFU_FLG_OVER] = flags_n[IAFU_FLG_CARRY];
      end
      IAFU_OP_SPROD: begin
        if (wsel) begin
          dest_n                  = ps16[15:0];
          ext_n                   = ps16[31:16];
          flags_n[IAFU_FLG_CARRY] = (ps16[31:16] != {16{ps16[15]}});
        end else begin
          dest_n                  = ps8;
          flags_n[IAFU_FLG_CARRY] = (ps8[15:8] != {8{ps8[7]}});
        end
        flags_n[IAFU_FLG_OVER] = flags_n[IAFU_FLG_CARRY];
      end
      IAFU_OP_UPROD_FIX: begin
        // Correct only if factors had clear upper nibbles
        t                        = acc_lo % IAFU_TEN;
        dest_n                   = {acc_lo / IAFU_TEN, t};
        flags_n[IAFU_FLG_PARITY] = even_ones(t);
        flags_n[IAFU_FLG_SIGN]   = t[7];
        flags_n[IAFU_FLG_ZERO]   = (t == 8'h00);
      end
      default: ;
    endcase
  end

  // ==========================================================================
  // Register file
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dest_q <= IAFU_RST_DATA;
    end else if (ce) begin
      if (exec) begin
        dest_q <= dest_n;
      end else if (wr_ack && avs_address == IAFU_OFS_DEST) begin
        dest_q <= merge_be(dest_q, avs_writedata, avs_byteenable);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      src_q <= IAFU_RST_DATA;
    end else if (ce && wr_ack && avs_address == IAFU_OFS_SRC) begin
      src_q <= merge_be(src_q, avs_writedata, avs_byteenable);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ext_q <= IAFU_RST_DATA;
    end else if (ce) begin
      if (exec) begin
        ext_q <= ext_n;
      end else if (wr_ack && avs_address == IAFU_OFS_EXT) begin
        ext_q <= merge_be(ext_q, avs_writedata, avs_byteenable);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      flags_q <= IAFU_RST_FLAGS;
    end else if (ce) begin
      if (exec) begin
        flags_q <= flags_n;
      end else if (wr_ack && avs_address == IAFU_OFS_FLAGS && avs_byteenable[0]) begin
        flags_q <= avs_writedata[IAFU_FLG_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      last_op_q   <= IAFU_RST_OP;
      last_word_q <= 1'b0;
    end else if (ce && exec) begin
      last_op_q   <= op;
      last_word_q <= wsel;
    end
  end

  // ==========================================================================
  // Outputs
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign acc_word        = dest_q;
  assign ext_word        = ext_q;
  assign flags           = flags_q;

endmodule : iafu_core

`default_nettype wire

/* verif/iafu_core_monitor.sv */
/*
  Checker for the arithmetic flag unit: bus answer timing and flag relations.
  Assumes it is bound to iafu_core and sees that module's ports only.
*/
`default_nettype none

module iafu_core_monitor
  import iafu_pkg::*;
(
  // Clock, reset, enable
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        ce,
  // Register bus
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Datapath state
  input wire logic [15:0] acc_word,
  input wire logic [15:0] ext_word,
  input wire logic [5:0]  flags
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // ==========================================================
  // Launch of an operation
  logic exec;
  logic word_op;
  assign exec    = avs_write && !avs_waitrequest && ce && avs_address == IAFU_OFS_CTRL && avs_byteenable[0];
  assign word_op = avs_writedata[IAFU_CTRL_WORD];

  sequence run_op(logic [3:0] op);
    exec && avs_writedata[3:0] == op;
  endsequence
  // Add/subtract family that stores its result, so parity and sign follow acc_word
  sequence arith_s;
    exec && avs_writedata[3:0] inside {4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h7, 4'h8};
  endsequence

  // ==========================================================
  // Assertions
  wait_pulse_a: assert property (!avs_waitrequest && ce |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest && ce |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  carry_keep_a: assert property (
    (run_op(IAFU_OP_PLUS1) or run_op(IAFU_OP_MINUS1)) |=> flags[IAFU_FLG_CARRY] == $past(flags[IAFU_FLG_CARRY]))
    else $error("carry changed by increment or decrement");
  twos_carry_a: assert property (run_op(IAFU_OP_TWOS) |=>
    flags[IAFU_FLG_CARRY] == ($past(word_op) ? acc_word != 16'h0000 : acc_word[7:0] != 8'h00))
    else $error("negate carry does not follow operand");
  compare_keep_a: assert property (run_op(IAFU_OP_COMPARE) |=> $stable(acc_word) && $stable(ext_word))
    else $error("compare changed an operand");
  uprod_flag_a: assert property (run_op(IAFU_OP_UPROD) |=>
    flags[IAFU_FLG_CARRY] == flags[IAFU_FLG_OVER] &&
    flags[IAFU_FLG_CARRY] == ($past(word_op) ? ext_word != 16'h0000 : acc_word[15:8] != 8'h00))
    else $error("unsigned product flags wrong");
  sprod_flag_a: assert property (run_op(IAFU_OP_SPROD) |=>
    flags[IAFU_FLG_CARRY] == flags[IAFU_FLG_OVER] &&
    flags[IAFU_FLG_CARRY] == ($past(word_op) ? ext_word != {16{acc_word[15]}} : acc_word[15:8] != {8{acc_word[7]}}))
    else $error("signed product flags wrong");
  parity_post_a: assert property (arith_s |=> flags[IAFU_FLG_PARITY] == ~^acc_word[7:0])
    else $error("parity flag wrong");
  sign_post_a: assert property (arith_s |=>
    flags[IAFU_FLG_SIGN] == ($past(word_op) ? acc_word[15] : acc_word[7]))
    else $error("sign flag wrong");
  digit_fix_a: assert property (
    (run_op(IAFU_OP_USUM_FIX) or run_op(IAFU_OP_UDIFF_FIX)) |=> acc_word[7:4] == 4'h0)
    else $error("unpacked fix left upper nibble set");
  prod_fix_a: assert property (run_op(IAFU_OP_UPROD_FIX) |=> acc_word[7:0] < 8'h0A &&
    {8'h00, acc_word[15:8]} * 16'h000A + {8'h00, acc_word[7:0]} == {8'h00, $past(acc_word[7:0])})
    else $error("product fix digits wrong");
endmodule : iafu_core_monitor

bind iafu_core iafu_core_monitor u_monitor (
  .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .acc_word(acc_word),
  .ext_word(ext_word), .flags(flags)
);

`default_nettype wire

/* verif/iafu_bus_model.sv */
/*
  Register-bus master standing in for the decoder and register file.
  Assumes the slave answers with waitrequest; every wait is bounded.
*/
`default_nettype none

module iafu_bus_model
  import iafu_pkg::*;
(
  // Clock
  input  wire logic        clk_sys,
  // Register bus, master side
  output var  logic [4:0]  avs_address,
  output var  logic        avs_read,
  output var  logic        avs_write,
  output var  logic [31:0] avs_writedata,
  output var  logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    avs_address    = 5'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'h0;
  end

  // ==========================================================
  // One access, entered just after a rising edge
  task automatic access(input logic rd, input logic [4:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] q, output logic ok);
    int n;
    n  = 0;
    ok = 1'b0;
    q  = 32'h0000_0000;
    avs_address    <= a;
    avs_read       <= rd;
    avs_write      <= !rd;
    avs_writedata  <= d;
    avs_byteenable <= be;
    while (n < 20 && !ok) begin
      @(posedge clk_sys);
      n++;
      if (!avs_waitrequest) begin
        ok = 1'b1;
        q  = avs_readdata;
      end
    end
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    // Released lines flip so a stale value is never mistaken for a live one
    avs_address   <= ~a;
    avs_writedata <= ~d;
    @(posedge clk_sys);
  endtask : access
endmodule : iafu_bus_model

`default_nettype wire

/* verif/tb_integer_arith_flag_unit.sv */
/*
  Self-checking bench for the arithmetic flag unit: one or two rows per operation.
  Assumes iafu_core, its package and the bus model are compiled first.
*/
`default_nettype none

module tb_integer_arith_flag_unit
  import iafu_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [3:0]  op;
    logic        wd;
    logic [15:0] dst, src;
    logic [5:0]  fin;
    logic [15:0] edst, eext;
    logic [5:0]  eflg, mask;
  } iafu_row_t;

  logic        clk_sys, resetn, ce, avs_read, avs_write, avs_waitrequest;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic [15:0] acc_word, ext_word;
  logic [5:0]  flags;
  iafu_row_t   rows[$];
  int          failures, comparisons;

  always #2.5 clk_sys = ~clk_sys;

  iafu_core DUT (
    .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .acc_word(acc_word),
    .ext_word(ext_word), .flags(flags));
  iafu_bus_model BUS (
    .clk_sys(clk_sys), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  // ==========================================================
  // Helpers
  task automatic finish_test();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic rd, input logic [4:0] a, input logic [15:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    logic ok;
    BUS.access(rd, a, {16'h0000, d}, be, q, ok);
    if (!ok) begin
      failures++;
      finish_test();
    end
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic [3:0] be = 4'h3);
    logic [31:0] q;
    bus(1'b0, a, d, be, q);
  endtask : wr

  task automatic rchk(input logic [4:0] a, input logic [15:0] exp, input logic [5:0] mask = 6'h3F);
    logic [31:0] q;
    bus(1'b1, a, 16'h0000, 4'hF, q);
    if (a == IAFU_OFS_FLAGS) begin
      q = q & {26'h000_0000, mask};
    end
    chk(q, {16'h0000, exp});
  endtask : rchk

  function automatic void put(logic [3:0] op, logic wd, logic [15:0] dst, src, logic [5:0] fin,
                              logic [15:0] edst, eext, logic [5:0] eflg, mask);
    rows.push_back({op, wd, dst, src, fin, edst, eext, eflg, mask});
  endfunction : put

  // ==========================================================
  // Main sequence
  initial begin
    clk_sys = 1'b0;
    resetn  = 1'b0;
    ce      = 1'b1;
    failures    = 0;
    comparisons = 0;
    put(4'h0, 1'b0, 16'h1238, 16'h00C9, 6'h00, 16'h1201, 16'h0000, 6'h05, 6'h3F);
    put(4'h1, 1'b0, 16'h0080, 16'h007F, 6'h01, 16'h0000, 16'h0000, 6'h0F, 6'h3F);
    put(4'h2, 1'b0, 16'h007F, 16'h0000, 6'h01, 16'h0080, 16'h0000, 6'h35, 6'h3F);
    put(4'h5, 1'b1, 16'h0000, 16'h0001, 6'h00, 16'hFFFF, 16'h0000, 6'h17, 6'h3F);
    put(4'h6, 1'b0, 16'h0080, 16'h0000, 6'h01, 16'h007F, 16'h0000, 6'h24, 6'h3F);
    put(4'h7, 1'b1, 16'h8000, 16'h0000, 6'h00, 16'h7FFF, 16'h0000, 6'h26, 6'h3F);
    put(4'h8, 1'b0, 16'h0080, 16'h0000, 6'h00, 16'h0080, 16'h0000, 6'h31, 6'h3F);
    put(4'h8, 1'b1, 16'h0000, 16'h0000, 6'h3F, 16'h0000, 16'h0000, 6'h0A, 6'h3F);
    put(4'h9, 1'b1, 16'h1234, 16'h1235, 6'h00, 16'h1234, 16'h0000, 6'h17, 6'h3F);
    put(4'h3, 1'b0, 16'h010B, 16'h0000, 6'h00, 16'h0201, 16'h0000, 6'h05, 6'h05);
    put(4'h4, 1'b0, 16'h009B, 16'h0000, 6'h00, 16'h0001, 16'h0000, 6'h05, 6'h1F);
    put(4'hA, 1'b0, 16'h030F, 16'h0000, 6'h00, 16'h0209, 16'h0000, 6'h05, 6'h05);
    put(4'hB, 1'b0, 16'h000F, 16'h0000, 6'h00, 16'h0009, 16'h0000, 6'h06, 6'h1F);
    put(4'hC, 1'b0, 16'h00FF, 16'h00FF, 6'h00, 16'hFE01, 16'h0000, 6'h21, 6'h21);
    put(4'hC, 1'b1, 16'h0100, 16'h0100, 6'h00, 16'h0000, 16'h0001, 6'h21, 6'h21);
    put(4'hD, 1'b0, 16'h00FF, 16'h0002, 6'h21, 16'hFFFE, 16'h0000, 6'h00, 6'h21);
    put(4'hD, 1'b1, 16'h4000, 16'h0002, 6'h00, 16'h8000, 16'h0000, 6'h21, 6'h21);
    put(4'hE, 1'b0, 16'h003F, 16'h0000, 6'h00, 16'h0603, 16'h0000, 6'h02, 6'h1A);
    // No-op command leaves every register as written
    put(4'hF, 1'b1, 16'h1234, 16'h5678, 6'h15, 16'h1234, 16'h0000, 6'h15, 6'h3F);
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rchk(IAFU_OFS_FLAGS, 16'h0000);
    rchk(IAFU_OFS_DEST, 16'h0000);
    foreach (rows[i]) begin
      wr(IAFU_OFS_FLAGS, {10'h000, rows[i].fin});
      wr(IAFU_OFS_DEST, rows[i].dst);
      wr(IAFU_OFS_SRC, rows[i].src);
      wr(IAFU_OFS_EXT, 16'h0000);
      wr(IAFU_OFS_CTRL, {11'h000, rows[i].wd, rows[i].op});
      rchk(IAFU_OFS_DEST, rows[i].edst);
      rchk(IAFU_OFS_EXT, rows[i].eext);
      rchk(IAFU_OFS_FLAGS, {10'h000, rows[i].eflg}, rows[i].mask);
    end
    // Last row leaves its source and command readable
    rchk(IAFU_OFS_SRC, 16'h5678);
    rchk(IAFU_OFS_CTRL, 16'h001F);
    // Unmapped place reads zero and ignores writes
    wr(5'h14, 16'hFFFF);
    rchk(5'h14, 16'h0000);
    // Control write without the low lane must not launch
    wr(IAFU_OFS_DEST, 16'h0001);
    wr(IAFU_OFS_CTRL, 16'h0002, 4'h2);
    rchk(IAFU_OFS_DEST, 16'h0001);
    // Reset in mid-run clears state at once
    resetn <= 1'b0;
    @(negedge clk_sys);
    chk({15'h0000, avs_waitrequest, acc_word}, 32'h0001_0000);
    @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rchk(IAFU_OFS_DEST, 16'h0000);
    finish_test();
  end
endmodule : tb_integer_arith_flag_unit

`default_nettype wire
